/* serial_mode_consts.vh */
// Constants for the port C, serial mode and clock control register bank.
// Assumes a 32-bit APB slave with word-aligned registers at four times the index.
`ifndef SERIAL_MODE_CONSTS_VH
`define SERIAL_MODE_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register indices as printed, and APB byte addresses derived from them.
`define IDX_PORT_C_DATA     8'h16
`define IDX_PORT_C_DIR      8'h17
`define IDX_SERIAL_STATUS   8'h1a
`define IDX_ENDPOINT_FLAGS  8'h1b
`define IDX_CLOCK_CONTROL   8'h1c
`define ADDR_SHIFT          2
`define ADDR_W              8
`define REG_W               8
`define DATA_W              32
`define PORT_W              4

////////////////////////////////////////////////////////////////////////////////
// Port C data register fields.
`define PC_GPIO_LSB         0
`define PC_GPIO_MSB         3
`define PC_PWM_FIRST_PIN    2
`define PC_PWM_SECOND_PIN   3
`define PC_PWM_CLK_SRC      5
`define PC_PWM_FIRST_EN     6
`define PC_PWM_SECOND_EN    7
`define PC_GPIO_RESET       4'h0
`define PC_DIR_RESET        4'hf

////////////////////////////////////////////////////////////////////////////////
// Serial status and control register fields.
`define SSC_SUSPEND         0
`define SSC_REMOTE_WAKEUP   1
`define SSC_BUS_RESET       2
`define SSC_RESUME_OUT      3
`define SSC_DATA_IN         4
`define SSC_CLOCK_IN        5
`define SSC_DATA_OUT        6
`define SSC_CLOCK_OUT       7

////////////////////////////////////////////////////////////////////////////////
// Endpoint flag and mode select register fields.
`define EFM_EP_COUNT        2
`define EFM_RSVD_LSB        2
`define EFM_RSVD_MSB        3
`define EFM_PS2_SEL         4
`define EFM_USB_SEL         5
`define EFM_ADC_REF         6
`define EFM_USB_IND         7
`define EFM_RSVD_RESET      2'h0

////////////////////////////////////////////////////////////////////////////////
// Clock control register fields.
`define CC_USB_CLK_GATE     3
`define CC_PULLUP_EN        4
`define CC_OSC_SEL          6
`define CC_PS2_IND          7

////////////////////////////////////////////////////////////////////////////////
// Quarter-rate tick divider.
`define TICK_DIV_W          2
`define TICK_DIV_LAST       2'h3
`define TICK_DIV_STEP       2'h1

`endif

/* sticky_flag.v */
// One sticky status flag set by a hardware pulse and cleared by software.
// Assumes set and clear are synchronous to clk; set wins over a same-cycle clear.
`timescale 1ns/100ps

module sticky_flag (
  input  wire clk,
  input  wire rstn,
  input  wire set,
  input  wire clear,
  output reg  flag
);

  // An event in the clearing cycle must survive, so set is tested first.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end

endmodule

/* serial_mode_regs.v */
// Port C, serial line mode, endpoint flag and clock control registers on APB.
// Assumes the SIE, PWM counters and ADC live outside and are synchronous to sys_clk.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "serial_mode_consts.vh"

module serial_mode_regs (
  input  wire                  sys_clk,
  input  wire                  rstn,
  // APB slave.
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [`ADDR_W-1:0]    paddr,
  input  wire [`DATA_W-1:0]    pwdata,
  output wire [`DATA_W-1:0]    prdata,
  output wire                  pready,
  output wire                  pslverr,
  // Port C pins.
  input  wire [`PORT_W-1:0]    port_c_pin_in,
  output reg  [`PORT_W-1:0]    port_c_pin_out,
  output reg  [`PORT_W-1:0]    port_c_pin_oe_n,
  // PWM side.
  input  wire                  pwm_first_wave,
  input  wire                  pwm_second_wave,
  output reg                   pwm_base_tick,
  // SIE side.
  input  wire                  usb_suspend,
  input  wire                  usb_bus_reset_event,
  input  wire                  usb_resume_out_event,
  input  wire [`EFM_EP_COUNT-1:0] endpoint_access,
  output wire [`EFM_EP_COUNT-1:0] endpoint_event_ready,
  output reg                   remote_wakeup_drive,
  input  wire                  sie_minus_out,
  input  wire                  sie_plus_out,
  input  wire                  sie_lines_oe_n,
  // CPU interrupt side.
  input  wire                  usb_int_enable,
  input  wire                  stack_full,
  output reg                   usb_int_request,
  // Serial lines, open-drain style in PS2 mode.
  input  wire                  minus_data_line_in,
  input  wire                  plus_data_line_in,
  output reg                   minus_data_line_out,
  output reg                   minus_data_line_oe_n,
  output reg                   plus_data_line_out,
  output reg                   plus_data_line_oe_n,
  // Mode and clock controls.
  output wire                  ps2_interface_select,
  output wire                  usb_interface_select,
  output wire                  adc_reference_select,
  output wire                  usb_clock_gate,
  output wire                  second_suspend_pullup_enable,
  output wire                  oscillator_frequency_select
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // Shared by the write path and the read path.
  function hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] idx;
    begin
      hit = (addr == (idx << `ADDR_SHIFT));
    end
  endfunction

  wire sel_pc  = hit(paddr, `IDX_PORT_C_DATA);
  wire sel_dir = hit(paddr, `IDX_PORT_C_DIR);
  wire sel_ssc = hit(paddr, `IDX_SERIAL_STATUS);
  wire sel_efm = hit(paddr, `IDX_ENDPOINT_FLAGS);
  wire sel_cc  = hit(paddr, `IDX_CLOCK_CONTROL);
  wire mapped  = sel_pc | sel_dir | sel_ssc | sel_efm | sel_cc;

  // Zero wait states: every access completes in its first access cycle.
  wire access  = psel & penable;
  wire wr      = access & pwrite & mapped;
  wire rd      = access & ~pwrite & mapped;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // Port C data and direction.

  reg [`PORT_W-1:0] port_c_data_reg;
  reg               pwm_clock_source;
  reg               pwm_first_output_enable;
  reg               pwm_second_output_enable;
  reg [`PORT_W-1:0] port_c_direction_reg;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      port_c_data_reg          <= `PC_GPIO_RESET;
      pwm_clock_source         <= 1'b0;
      pwm_first_output_enable  <= 1'b0;
      pwm_second_output_enable <= 1'b0;
      port_c_direction_reg     <= `PC_DIR_RESET;
    end else begin
      if (wr && sel_pc) begin
        port_c_data_reg          <= pwdata[`PC_GPIO_MSB:`PC_GPIO_LSB];
        pwm_clock_source         <= pwdata[`PC_PWM_CLK_SRC];
        pwm_first_output_enable  <= pwdata[`PC_PWM_FIRST_EN];
        pwm_second_output_enable <= pwdata[`PC_PWM_SECOND_EN];
      end
      if (wr && sel_dir) begin
        port_c_direction_reg <= pwdata[`PC_GPIO_MSB:`PC_GPIO_LSB];
      end
    end
  end

  // A direction bit of 1 makes the pin an input. An enabled PWM owns its pin
  // whatever the direction bit says.
  always @* begin
    port_c_pin_out  = port_c_data_reg;
    port_c_pin_oe_n = port_c_direction_reg;
    if (pwm_first_output_enable) begin
      port_c_pin_out[`PC_PWM_FIRST_PIN]  = pwm_first_wave;
      port_c_pin_oe_n[`PC_PWM_FIRST_PIN] = 1'b0;
    end
    if (pwm_second_output_enable) begin
      port_c_pin_out[`PC_PWM_SECOND_PIN]  = pwm_second_wave;
      port_c_pin_oe_n[`PC_PWM_SECOND_PIN] = 1'b0;
    end
  end

  // Pins set as inputs read the pad; outputs read back the latch.
  wire [`PORT_W-1:0] port_c_read = (port_c_pin_in & port_c_direction_reg) |
                                   (port_c_data_reg & ~port_c_direction_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // PWM base tick.

  reg [`TICK_DIV_W-1:0] tick_div;
  wire                  quarter_rate_tick = (tick_div == `TICK_DIV_LAST);

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_div      <= {`TICK_DIV_W{1'b0}};
      pwm_base_tick <= 1'b0;
    end else begin
      tick_div      <= tick_div + `TICK_DIV_STEP;
      pwm_base_tick <= pwm_clock_source ? 1'b1 : quarter_rate_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial status and control.

  reg  ps2_line_data_out;
  reg  ps2_line_clock_out;
  wire bus_reset_event_flag;
  wire resume_out_flag;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      remote_wakeup_drive <= 1'b0;
      ps2_line_data_out   <= 1'b1;
      ps2_line_clock_out  <= 1'b1;
    end else if (wr && sel_ssc) begin
      remote_wakeup_drive <= pwdata[`SSC_REMOTE_WAKEUP];
      ps2_line_data_out   <= pwdata[`SSC_DATA_OUT];
      ps2_line_clock_out  <= pwdata[`SSC_CLOCK_OUT];
    end
  end

  // Bus reset flag: firmware writing 0 clears it; a reset event wins.
  sticky_flag u_bus_reset_flag (
    .clk   (sys_clk),
    .rstn  (rstn),
    .set   (usb_bus_reset_event),
    .clear (wr && sel_ssc && !pwdata[`SSC_BUS_RESET]),
    .flag  (bus_reset_event_flag)
  );

  // Resume-out is read-only, so reading the register is what clears it.
  sticky_flag u_resume_out_flag (
    .clk   (sys_clk),
    .rstn  (rstn),
    .set   (usb_resume_out_event),
    .clear (rd && sel_ssc),
    .flag  (resume_out_flag)
  );

  // A line held low by our own output bit reads 0, which is why firmware
  // must release it before sampling.
  wire ps2_line_data_in  = minus_data_line_in;
  wire ps2_line_clock_in = plus_data_line_in;

  ////////////////////////////////////////////////////////////////////////////////
  // Endpoint flags and mode select.

  wire [`EFM_EP_COUNT-1:0] endpoint_flag;
  reg  [`EFM_EP_COUNT-1:0] endpoint_flag_q;
  reg  [`EFM_RSVD_MSB:`EFM_RSVD_LSB] endpoint_reserved;
  reg  ps2_sel;
  reg  usb_sel;
  reg  adc_ref;
  reg  usb_indicator;

  genvar g;
  generate
    for (g = 0; g < `EFM_EP_COUNT; g = g + 1) begin : g_ep
      sticky_flag u_ep_flag (
        .clk   (sys_clk),
        .rstn  (rstn),
        .set   (endpoint_access[g] && !endpoint_flag[g]),
        .clear (wr && sel_efm && !pwdata[g]),
        .flag  (endpoint_flag[g])
      );
    end
  endgenerate

  // The SIE holds a further event for an endpoint until its flag reads 0.
  assign endpoint_event_ready = ~endpoint_flag;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      endpoint_flag_q   <= {`EFM_EP_COUNT{1'b0}};
      usb_int_request   <= 1'b0;
      endpoint_reserved <= `EFM_RSVD_RESET;
      ps2_sel           <= 1'b0;
      usb_sel           <= 1'b0;
      adc_ref           <= 1'b1;
      usb_indicator     <= 1'b0;
    end else begin
      endpoint_flag_q <= endpoint_flag;
      // One request pulse per cycle with any newly set flag, dropped while the stack is full.
      usb_int_request <= |(endpoint_flag & ~endpoint_flag_q) & usb_int_enable & ~stack_full;
      if (wr && sel_efm) begin
        endpoint_reserved <= pwdata[`EFM_RSVD_MSB:`EFM_RSVD_LSB];
        ps2_sel           <= pwdata[`EFM_PS2_SEL];
        usb_sel           <= pwdata[`EFM_USB_SEL];
        adc_ref           <= pwdata[`EFM_ADC_REF];
        usb_indicator     <= pwdata[`EFM_USB_IND];
      end
    end
  end

  assign ps2_interface_select = ps2_sel;
  assign usb_interface_select = usb_sel;
  assign adc_reference_select = adc_ref;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock control.

  reg usb_clk_on;
  reg pullup_on;
  reg osc_six;
  reg ps2_indicator;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      usb_clk_on    <= 1'b0;
      pullup_on     <= 1'b0;
      osc_six       <= 1'b0;
      ps2_indicator <= 1'b0;
    end else if (wr && sel_cc) begin
      usb_clk_on    <= pwdata[`CC_USB_CLK_GATE];
      pullup_on     <= pwdata[`CC_PULLUP_EN];
      osc_six       <= pwdata[`CC_OSC_SEL];
      ps2_indicator <= pwdata[`CC_PS2_IND];
    end
  end

  assign usb_clock_gate               = usb_clk_on;
  assign second_suspend_pullup_enable = pullup_on;
  assign oscillator_frequency_select  = osc_six;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial line ownership.

  // PS2 lines are open-drain: a 0 bit pulls low, a 1 bit lets the line float.
  always @* begin
    minus_data_line_out  = 1'b0;
    plus_data_line_out   = 1'b0;
    minus_data_line_oe_n = 1'b1;
    plus_data_line_oe_n  = 1'b1;
    if (ps2_sel && !usb_sel) begin
      minus_data_line_oe_n = ps2_line_data_out;
      plus_data_line_oe_n  = ps2_line_clock_out;
    end else if (usb_sel && !ps2_sel) begin
      minus_data_line_out  = sie_minus_out;
      plus_data_line_out   = sie_plus_out;
      minus_data_line_oe_n = sie_lines_oe_n;
      plus_data_line_oe_n  = sie_lines_oe_n;
    end
    // Both selects equal leaves the released defaults above.
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data.

  reg [`REG_W-1:0] read_byte;
  reg [`DATA_W-1:0] prdata_q;

  always @* begin
    read_byte = {`REG_W{1'b0}};
    if (sel_pc) begin
      read_byte[`PC_GPIO_MSB:`PC_GPIO_LSB] = port_c_read;
      read_byte[`PC_PWM_CLK_SRC]           = pwm_clock_source;
      read_byte[`PC_PWM_FIRST_EN]          = pwm_first_output_enable;
      read_byte[`PC_PWM_SECOND_EN]         = pwm_second_output_enable;
    end else if (sel_dir) begin
      read_byte[`PC_GPIO_MSB:`PC_GPIO_LSB] = port_c_direction_reg;
    end else if (sel_ssc) begin
      read_byte[`SSC_SUSPEND]    = usb_suspend;
      read_byte[`SSC_BUS_RESET]  = bus_reset_event_flag;
      read_byte[`SSC_RESUME_OUT] = resume_out_flag;
      read_byte[`SSC_DATA_IN]    = ps2_line_data_in;
      read_byte[`SSC_CLOCK_IN]   = ps2_line_clock_in;
    end else if (sel_efm) begin
      read_byte[`EFM_EP_COUNT-1:0]          = endpoint_flag;
      read_byte[`EFM_RSVD_MSB:`EFM_RSVD_LSB] = endpoint_reserved;
      read_byte[`EFM_PS2_SEL]               = ps2_sel;
      read_byte[`EFM_USB_SEL]               = usb_sel;
      read_byte[`EFM_ADC_REF]               = adc_ref;
      read_byte[`EFM_USB_IND]               = usb_indicator;
    end else if (sel_cc) begin
      read_byte[`CC_USB_CLK_GATE] = usb_clk_on;
      read_byte[`CC_PULLUP_EN]    = pullup_on;
      read_byte[`CC_OSC_SEL]      = osc_six;
      read_byte[`CC_PS2_IND]      = ps2_indicator;
    end
  end

  // Read data is registered in the setup cycle so it stands through the access.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_q <= {`DATA_W{1'b0}};
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= {{(`DATA_W-`REG_W){1'b0}}, read_byte};
    end
  end

  assign prdata = prdata_q;

endmodule

/* serial_mode_regs_chk.sv */
// Concurrent checks on the serial mode register bank ports.
// Assumes APB writes land at the access edge, as pready is always high.
`timescale 1ns/100ps

module serial_mode_regs_chk (
  input wire        sys_clk,
  input wire        rstn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  port_c_pin_out,
  input wire [3:0]  port_c_pin_oe_n,
  input wire        pwm_first_wave,
  input wire        pwm_second_wave,
  input wire        pwm_base_tick,
  input wire [1:0]  endpoint_access,
  input wire [1:0]  endpoint_event_ready,
  input wire        remote_wakeup_drive,
  input wire        sie_minus_out,
  input wire        sie_plus_out,
  input wire        sie_lines_oe_n,
  input wire        usb_int_enable,
  input wire        stack_full,
  input wire        usb_int_request,
  input wire        minus_data_line_out,
  input wire        minus_data_line_oe_n,
  input wire        plus_data_line_out,
  input wire        plus_data_line_oe_n,
  input wire        ps2_interface_select,
  input wire        usb_interface_select,
  input wire        adc_reference_select,
  input wire        usb_clock_gate,
  input wire        second_suspend_pullup_enable,
  input wire        oscillator_frequency_select
);
  // Mirrors of the written control bits, so each output is tied to its cause.
  reg [7:0] pc, dir, ssc, efm, cc;
  reg [2:0] src_low;
  wire      wr      = psel & penable & pwrite;
  wire      clr_ep1 = wr && paddr == 8'h6c && !pwdata[1];

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pc <= 8'h00;
      dir <= 8'h0f;
      ssc <= 8'hc0;
      efm <= 8'h40;
      cc <= 8'h00;
    end else if (wr) begin
      if (paddr == 8'h58)
        pc <= pwdata[7:0];
      if (paddr == 8'h5c)
        dir <= pwdata[7:0];
      if (paddr == 8'h68)
        ssc <= pwdata[7:0];
      if (paddr == 8'h6c)
        efm <= pwdata[7:0];
      if (paddr == 8'h70)
        cc <= pwdata[7:0];
    end
  end

  // The slow tick is only judged once its source has been settled for a while.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      src_low <= 3'h0;
    else if (pc[5])
      src_low <= 3'h0;
    else if (src_low != 3'h7)
      src_low <= src_low + 3'h1;
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence ep0_hit;
    endpoint_access[0] && endpoint_event_ready[0] ##1 usb_int_enable && !stack_full;
  endsequence

  a_int_after_hit: assert property (ep0_hit |-> ##1 usb_int_request)
    else $error("no interrupt after endpoint hit");
  a_int_cause: assert property (usb_int_request |-> $past(usb_int_enable) && !$past(stack_full))
    else $error("interrupt while disabled or stack full");
  a_flag_sets: assert property (endpoint_access[1] |=> !endpoint_event_ready[1])
    else $error("endpoint flag not set");
  a_flag_holds: assert property (!endpoint_event_ready[1] && !clr_ep1 |=> !endpoint_event_ready[1])
    else $error("endpoint flag lost");
  a_gpio_pins: assert property (port_c_pin_out[1:0] == pc[1:0] && port_c_pin_oe_n[1:0] == dir[1:0])
    else $error("port pins differ from registers");
  a_pwm_first: assert property (pc[6] |-> !port_c_pin_oe_n[2] && port_c_pin_out[2] == pwm_first_wave)
    else $error("first pwm not on pin");
  a_pwm_second: assert property (pc[7] |-> !port_c_pin_oe_n[3] && port_c_pin_out[3] == pwm_second_wave)
    else $error("second pwm not on pin");
  a_tick_fast: assert property (pc[5] && $past(pc[5]) |-> pwm_base_tick)
    else $error("tick not every cycle");
  a_tick_quarter: assert property (pwm_base_tick && src_low == 3'h7 |=>
    (!pwm_base_tick || pc[5]) [*3] ##1 (pwm_base_tick || pc[5])) else $error("tick not every fourth cycle");
  a_ps2_lines: assert property (ps2_interface_select && !usb_interface_select |->
    minus_data_line_oe_n == ssc[6] && plus_data_line_oe_n == ssc[7] && !minus_data_line_out && !plus_data_line_out)
    else $error("ps2 lines not under firmware");
  a_usb_lines: assert property (!ps2_interface_select && usb_interface_select |->
    minus_data_line_oe_n == sie_lines_oe_n && plus_data_line_oe_n == sie_lines_oe_n
    && minus_data_line_out == sie_minus_out && plus_data_line_out == sie_plus_out) else $error("usb lines wrong");
  a_lines_free: assert property (ps2_interface_select == usb_interface_select |->
    minus_data_line_oe_n && plus_data_line_oe_n) else $error("lines not released");
  a_mode_bits: assert property ({ps2_interface_select, usb_interface_select, adc_reference_select}
    == {efm[4], efm[5], efm[6]}) else $error("mode outputs wrong");
  a_clock_bits: assert property ({usb_clock_gate, second_suspend_pullup_enable, oscillator_frequency_select}
    == {cc[3], cc[4], cc[6]}) else $error("clock outputs wrong");
  a_wakeup_level: assert property (remote_wakeup_drive == ssc[1])
    else $error("wakeup drive wrong");
endmodule

bind serial_mode_regs serial_mode_regs_chk chk (.*);

/* ps2_host_model.sv */
// Far side of the serial lines: pull-ups plus a host that may pull low.
// Assumes the device drives a line only while its oe_n is low.
`timescale 1ns/100ps

module ps2_host_model (
  input  wire dev_minus_out,
  input  wire dev_minus_oe_n,
  input  wire dev_plus_out,
  input  wire dev_plus_oe_n,
  input  wire host_pull_data,
  input  wire host_pull_clock,
  output wire minus_level,
  output wire plus_level
);
  // A released line floats up to the pull-up, never holding a stale value.
  assign minus_level = (dev_minus_oe_n ? 1'b1 : dev_minus_out) & ~host_pull_data;
  assign plus_level  = (dev_plus_oe_n ? 1'b1 : dev_plus_out) & ~host_pull_clock;
endmodule

/* tb.sv */
// Self-checking bench for the serial mode register bank over APB.
// Assumes the host model supplies the serial line levels.
`timescale 1ns/100ps

module tb;
  logic        sys_clk = 1'b0;
  logic        rstn, psel, penable, pwrite, err, host_pull_data;
  logic [7:0]  paddr;
  logic [31:0] pwdata, q, n_mismatch, n_compared, n_int, cyc;
  logic [3:0]  port_c_pin_in;
  logic [1:0]  pwm_wave, endpoint_access;
  logic        usb_suspend, usb_bus_reset_event, usb_resume_out_event, sie_minus_out, sie_plus_out;
  logic        sie_lines_oe_n, usb_int_enable, stack_full;
  wire  [31:0] prdata;
  wire  [3:0]  port_c_pin_out, port_c_pin_oe_n;
  wire  [1:0]  endpoint_event_ready;
  wire         pready, pslverr, pwm_base_tick, remote_wakeup_drive, usb_int_request;
  wire         minus_data_line_in, plus_data_line_in, minus_data_line_out, minus_data_line_oe_n;
  wire         plus_data_line_out, plus_data_line_oe_n, ps2_interface_select, usb_interface_select;
  wire         adc_reference_select, usb_clock_gate, second_suspend_pullup_enable, oscillator_frequency_select;
  wire         pwm_first_wave  = pwm_wave[0];
  wire         pwm_second_wave = pwm_wave[1];
  logic [7:0]  reg_addr [5] = '{8'h58, 8'h5c, 8'h68, 8'h6c, 8'h70};
  logic [7:0]  reg_init [5] = '{8'h05, 8'h0f, 8'h30, 8'h40, 8'h00};
  integer      i;

  serial_mode_regs uut (.*);
  ps2_host_model host (.dev_minus_out(minus_data_line_out), .dev_minus_oe_n(minus_data_line_oe_n),
    .dev_plus_out(plus_data_line_out), .dev_plus_oe_n(plus_data_line_oe_n), .host_pull_data(host_pull_data),
    .host_pull_clock(1'b0), .minus_level(minus_data_line_in), .plus_level(plus_data_line_in));

  always #2.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    pwm_wave <= pwm_wave + 2'h1;
    cyc <= cyc + 32'h1;
    if (usb_int_request === 1'b1)
      n_int <= n_int + 32'h1;
    if (cyc == 32'd2000) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch at %0t got %h expected %h", $time, cyc, 32'd2000);
      final_report;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task final_report;
    begin
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t got %h expected %h", $time, g, e);
      end
    end
  endtask

  // The request stays put until pready is seen high, for at most 20 cycles; no latency is assumed.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer k;
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge sys_clk);
        k = k + 1;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t got %h expected %h", $time, pready, 1'b1);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(q, {24'h0, e});
    end
  endtask

  task ep(input logic [1:0] m);
    begin
      @(posedge sys_clk);
      endpoint_access <= m;
      @(posedge sys_clk);
      endpoint_access <= 2'b00;
      repeat (3) @(posedge sys_clk);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    n_int = 0;
    cyc = 0;
    pwm_wave = 2'h0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    port_c_pin_in = 4'h5;
    usb_suspend = 1'b0;
    usb_bus_reset_event = 1'b0;
    usb_resume_out_event = 1'b0;
    endpoint_access = 2'b00;
    sie_minus_out = 1'b0;
    sie_plus_out = 1'b0;
    sie_lines_oe_n = 1'b1;
    usb_int_enable = 1'b1;
    stack_full = 1'b0;
    host_pull_data = 1'b0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    for (i = 0; i < 5; i = i + 1)
      rd(reg_addr[i], reg_init[i]);
    apb(1'b0, 8'h60, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(8'h5c, 32'hffff_fff3);
    rd(8'h5c, 8'h03);
    // Pins 0 and 1 are inputs and read the pad; pins 2 and 3 are outputs and read the latch.
    wr(8'h58, 32'h0000_00ff);
    rd(8'h58, 8'hed);
    wr(8'h58, 32'h0000_000f);
    rd(8'h58, 8'h0d);
    repeat (16) @(posedge sys_clk);
    wr(8'h70, 32'h0000_00ff);
    rd(8'h70, 8'hd8);
    wr(8'h6c, 32'h0000_0050);
    rd(8'h6c, 8'h50);
    wr(8'h68, 32'h0000_0040);
    rd(8'h68, 8'h10);
    host_pull_data <= 1'b1;
    rd(8'h68, 8'h00);
    host_pull_data <= 1'b0;
    wr(8'h68, 32'h0000_0080);
    rd(8'h68, 8'h20);
    wr(8'h68, 32'h0000_00c0);
    sie_lines_oe_n <= 1'b0;
    sie_minus_out <= 1'b1;
    usb_suspend <= 1'b1;
    wr(8'h6c, 32'h0000_0020);
    rd(8'h68, 8'h11);
    wr(8'h6c, 32'h0000_0030);
    rd(8'h68, 8'h31);
    @(posedge sys_clk);
    usb_bus_reset_event <= 1'b1;
    usb_resume_out_event <= 1'b1;
    @(posedge sys_clk);
    usb_bus_reset_event <= 1'b0;
    usb_resume_out_event <= 1'b0;
    rd(8'h68, 8'h3d);
    rd(8'h68, 8'h35);
    wr(8'h68, 32'h0000_00c2);
    rd(8'h68, 8'h31);
    ep(2'b01);
    chk(n_int, 32'h1);
    ep(2'b01);
    chk(n_int, 32'h1);
    stack_full <= 1'b1;
    ep(2'b10);
    chk(n_int, 32'h1);
    rd(8'h6c, 8'h33);
    wr(8'h6c, 32'h0000_0030);
    rd(8'h6c, 8'h30);
    stack_full <= 1'b0;
    ep(2'b10);
    chk(n_int, 32'h2);
    final_report;
  end
endmodule
